// ===== common/mtac_pkg.sv
// Constants, register map and carrier types for the monitor threshold and alarm block
package mtac_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // Register indexes; the byte address is four times the index
    localparam logic [5:0] IDX_VOLTAGE_GAIN = 6'h15;
    localparam logic [5:0] IDX_RESERVED_16 = 6'h16;
    localparam logic [5:0] IDX_MON_CTRL_A = 6'h17;
    localparam logic [5:0] IDX_MON_CTRL_B = 6'h18;
    localparam logic [5:0] IDX_PIN0_LIMITS = 6'h19;
    localparam logic [5:0] IDX_PIN1_LIMITS = 6'h1a;
    localparam logic [5:0] IDX_TEMP_LIMITS = 6'h1b;
    localparam logic [5:0] IDX_RX_ALARM_EN = 6'h1c;
    localparam logic [5:0] IDX_MON_ALARM_EN = 6'h1d;
    localparam logic [5:0] IDX_BC_ALARM_EN = 6'h1e;
    localparam logic [5:0] IDX_EVENT_STATUS = 6'h30;
    localparam logic [5:0] IDX_EVENT_MASK = 6'h31;

    // Reset values
    localparam logic [7:0] RST_VOLTAGE_GAIN = 8'h20;
    localparam logic [7:0] RST_RESERVED_16 = 8'h18;
    localparam logic [7:0] RST_MON_CTRL_A = 8'h0c;
    localparam logic [7:0] RST_MON_CTRL_B = 8'h80;
    localparam logic [7:0] RST_LIMITS = 8'h62;
    localparam logic [7:0] RST_RX_ALARM_EN = 8'h3f;
    localparam logic [7:0] RST_MON_ALARM_EN = 8'h00;
    localparam logic [7:0] RST_BC_ALARM_EN = 8'h00;
    localparam logic [5:0] RST_EVENTS = 6'h00;

    // Field positions
    localparam int GAIN_CODE_MSB = 6;
    localparam int MON_EN_MSB = 3;
    localparam int MON_EN_LSB = 2;
    localparam int PIN_SEL_MSB = 1;
    localparam int PIN_SEL_LSB = 0;
    localparam int GAIN_APPLY_BIT = 7;
    localparam int UPPER_MSB = 6;
    localparam int UPPER_LSB = 4;
    localparam int LOWER_MSB = 2;
    localparam int LOWER_LSB = 0;
    localparam int RX_STS_LSB = 8;
    localparam logic [1:0] MON_EN_ON = 2'b11;

    // Monitor event bit positions, shared by status, mask and alarm enables
    localparam int EV_TEMP_HIGH = 5;
    localparam int EV_TEMP_LOW = 4;
    localparam int EV_PIN1_HIGH = 3;
    localparam int EV_PIN1_LOW = 2;
    localparam int EV_PIN0_HIGH = 1;
    localparam int EV_PIN0_LOW = 0;

    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef struct packed {
        logic valid;
        logic [2:0] pin0_level;
        logic [2:0] pin1_level;
        logic [2:0] temp_level;
    } mtac_meas_s;

    typedef struct packed {
        logic monitor_on;
        logic [1:0] pin_select;
        logic [6:0] voltage_gain_code;
        logic gain_apply;
    } mtac_cfg_s;
endpackage

// ===== core/mtac_core.sv
// Monitor configuration, threshold qualification and alarm gating behind AXI4-Lite
// Operation
// RULE1: A 7-bit gain code resets to 0x20 and sets an effective gain of 128 divided by the code.
// RULE2: The 2-bit monitor enable in bits 3:2 powers the monitor at 11, disables it at 00, and resets to on.
// RULE3: The 2-bit pin select picks none, pin 0, pin 1 or both for sensing and resets to none.
// RULE4: The gain-apply bit in bit 7 enables use of the gain code and resets to 1.
// RULE5: With pin 0 sensing, a level above the pin 0 upper limit (bits 6:4, reset 6) sets the pin 0 high flag.
// RULE6: With pin 0 sensing, a level below the pin 0 lower limit (bits 2:0, reset 2) sets the pin 0 low flag.
// RULE7: With pin 1 sensing, a level above the pin 1 upper limit (bits 6:4, reset 6) sets the pin 1 high flag.
// RULE8: With pin 1 sensing, a level below the pin 1 lower limit (bits 2:0, reset 2) sets the pin 1 low flag.
// RULE9: With the monitor on, a temperature above the upper limit (bits 6:4, reset 6) sets the temp high flag.
// RULE10: With the monitor on, a temperature below the lower limit (bits 2:0, reset 2) sets the temp low flag.
// RULE11: Receiver alarm enables for no frame, lane sync, lane control and header ECC sit in bits 5:2, reset 1.
// RULE12: Receiver alarm enables for checksum (bit 1) and length (bit 0) reset to 1 and 0 disables them.
// RULE13: Monitor alarm enables for temperature high (bit 5) and low (bit 4) reset to 0.
// RULE14: Monitor alarm enables for pin 1 high/low (bits 3/2) and pin 0 high/low (bits 1/0) reset to 0.
// RULE15: An alarm output rises only for a present condition with its enable set; flags record regardless. Code gates the latched flags instead.
`timescale 1ns/100ps
module mtac_core (
    input wire logic i_mclk,
    input wire logic i_srst,
    input wire logic [mtac_pkg::ADDR_W-1:0] i_s_axi_awaddr,
    input wire logic i_s_axi_awvalid,
    output logic o_s_axi_awready,
    input wire logic [mtac_pkg::DATA_W-1:0] i_s_axi_wdata,
    input wire logic [3:0] i_s_axi_wstrb,
    input wire logic i_s_axi_wvalid,
    output logic o_s_axi_wready,
    output logic [1:0] o_s_axi_bresp,
    output logic o_s_axi_bvalid,
    input wire logic i_s_axi_bready,
    input wire logic [mtac_pkg::ADDR_W-1:0] i_s_axi_araddr,
    input wire logic i_s_axi_arvalid,
    output logic o_s_axi_arready,
    output logic [mtac_pkg::DATA_W-1:0] o_s_axi_rdata,
    output logic [1:0] o_s_axi_rresp,
    output logic o_s_axi_rvalid,
    input wire logic i_s_axi_rready,
    input wire mtac_pkg::mtac_meas_s i_meas,
    input wire logic [5:0] i_rx_err,
    output mtac_pkg::mtac_cfg_s o_cfg,
    output logic o_monitor_alarm,
    output logic o_rx_alarm,
    output logic o_irq
);
    import mtac_pkg::*;

    typedef struct packed {
        logic [7:0] voltage_gain;
        logic [7:0] reserved_16;
        logic [7:0] monitor_control_a;
        logic [7:0] monitor_control_b;
        logic [7:0] pin0_voltage_limits;
        logic [7:0] pin1_voltage_limits;
        logic [7:0] temperature_limits;
        logic [7:0] receiver_alarm_enables;
        logic [7:0] monitor_alarm_enables;
        logic [7:0] back_channel_alarm_enables;
        logic [5:0] mon_sts;
        logic [5:0] rx_sts;
        logic [5:0] mon_msk;
        logic [5:0] rx_msk;
        logic aw_got;
        logic [5:0] aw_idx;
        logic w_got;
        logic [7:0] w_byte;
        logic w_lane0;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [DATA_W-1:0] rdata;
    } mtac_state_s;

    mtac_state_s st_q;
    mtac_state_s st_d;

    logic [5:0] mon_set;
    logic [5:0] lim_up [3];
    logic [2:0] level [3];
    logic [2:0] upper [3];
    logic [2:0] lower [3];
    logic [2:0] chan_on;
    logic monitor_on;
    logic [5:0] rd_idx;
    logic [DATA_W-1:0] rd_data;
    logic rd_hit;
    logic wr_hit;
    logic aw_take;
    logic w_take;
    logic ar_take;
    logic do_write;

    // Monitor is powered only at the fully-on code; 01 and 10 count as off
    assign monitor_on = (st_q.monitor_control_a[MON_EN_MSB:MON_EN_LSB] == MON_EN_ON); // RULE2

    // Channel 0 is pin 0, channel 1 is pin 1, channel 2 is temperature
    assign level[0] = i_meas.pin0_level;
    assign level[1] = i_meas.pin1_level;
    assign level[2] = i_meas.temp_level;
    assign upper[0] = st_q.pin0_voltage_limits[UPPER_MSB:UPPER_LSB];
    assign lower[0] = st_q.pin0_voltage_limits[LOWER_MSB:LOWER_LSB];
    assign upper[1] = st_q.pin1_voltage_limits[UPPER_MSB:UPPER_LSB];
    assign lower[1] = st_q.pin1_voltage_limits[LOWER_MSB:LOWER_LSB];
    assign upper[2] = st_q.temperature_limits[UPPER_MSB:UPPER_LSB];
    assign lower[2] = st_q.temperature_limits[LOWER_MSB:LOWER_LSB];
    assign chan_on[0] = monitor_on && st_q.monitor_control_a[PIN_SEL_LSB]; // RULE3
    assign chan_on[1] = monitor_on && st_q.monitor_control_a[PIN_SEL_MSB]; // RULE3
    assign chan_on[2] = monitor_on;

    // Pair per channel: bit 1 over upper limit, bit 0 under lower limit
    for (genvar c = 0; c < 3; c++) begin : g_chan
        assign lim_up[c] = {4'h0, i_meas.valid && chan_on[c] && (level[c] > upper[c]),
                            i_meas.valid && chan_on[c] && (level[c] < lower[c])};
    end

    assign mon_set = {lim_up[2][1:0], lim_up[1][1:0], lim_up[0][1:0]}; // RULE5 RULE6 RULE7 RULE8 RULE9 RULE10

    // AXI handshakes; one write response and one read answer at a time
    assign o_s_axi_awready = !st_q.aw_got && !st_q.bvalid;
    assign o_s_axi_wready = !st_q.w_got && !st_q.bvalid;
    assign o_s_axi_arready = !st_q.rvalid;
    assign aw_take = i_s_axi_awvalid && o_s_axi_awready;
    assign w_take = i_s_axi_wvalid && o_s_axi_wready;
    assign ar_take = i_s_axi_arvalid && o_s_axi_arready;
    assign do_write = st_q.aw_got && st_q.w_got && !st_q.bvalid;
    assign rd_idx = i_s_axi_araddr[ADDR_W-1:2];

    always_comb begin
        rd_hit = 1'b1;
        rd_data = '0;
        case (rd_idx)
            IDX_VOLTAGE_GAIN: begin
                rd_data[7:0] = st_q.voltage_gain;
            end
            IDX_RESERVED_16: begin
                rd_data[7:0] = st_q.reserved_16;
            end
            IDX_MON_CTRL_A: begin
                rd_data[7:0] = st_q.monitor_control_a;
            end
            IDX_MON_CTRL_B: begin
                rd_data[7:0] = st_q.monitor_control_b;
            end
            IDX_PIN0_LIMITS: begin
                rd_data[7:0] = st_q.pin0_voltage_limits;
            end
            IDX_PIN1_LIMITS: begin
                rd_data[7:0] = st_q.pin1_voltage_limits;
            end
            IDX_TEMP_LIMITS: begin
                rd_data[7:0] = st_q.temperature_limits;
            end
            IDX_RX_ALARM_EN: begin
                rd_data[7:0] = st_q.receiver_alarm_enables;
            end
            IDX_MON_ALARM_EN: begin
                rd_data[7:0] = st_q.monitor_alarm_enables;
            end
            IDX_BC_ALARM_EN: begin
                rd_data[7:0] = st_q.back_channel_alarm_enables;
            end
            IDX_EVENT_STATUS: begin
                rd_data[RX_STS_LSB+5:RX_STS_LSB] = st_q.rx_sts;
                rd_data[5:0] = st_q.mon_sts;
            end
            IDX_EVENT_MASK: begin
                rd_data[RX_STS_LSB+5:RX_STS_LSB] = st_q.rx_msk;
                rd_data[5:0] = st_q.mon_msk;
            end
            default: begin
                rd_hit = 1'b0;
            end
        endcase
    end

    always_comb begin
        case (st_q.aw_idx)
            IDX_VOLTAGE_GAIN, IDX_RESERVED_16, IDX_MON_CTRL_A, IDX_MON_CTRL_B, IDX_PIN0_LIMITS,
            IDX_PIN1_LIMITS, IDX_TEMP_LIMITS, IDX_RX_ALARM_EN, IDX_MON_ALARM_EN, IDX_BC_ALARM_EN,
            IDX_EVENT_STATUS, IDX_EVENT_MASK: begin
                wr_hit = 1'b1;
            end
            default: begin
                wr_hit = 1'b0;
            end
        endcase
    end

    always_comb begin
        st_d = st_q;
        if (aw_take) begin
            st_d.aw_got = 1'b1;
            st_d.aw_idx = i_s_axi_awaddr[ADDR_W-1:2];
        end
        if (w_take) begin
            st_d.w_got = 1'b1;
            st_d.w_byte = i_s_axi_wdata[7:0];
            st_d.w_lane0 = i_s_axi_wstrb[0];
        end
        if (do_write) begin
            st_d.aw_got = 1'b0;
            st_d.w_got = 1'b0;
            st_d.bvalid = 1'b1;
            st_d.bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
            // Writes use lane 0 only; other lanes, including the receiver mask bits in lane 1, are ignored
            if (st_q.w_lane0) begin
                case (st_q.aw_idx)
                    IDX_VOLTAGE_GAIN: begin
                        st_d.voltage_gain = st_q.w_byte; // RULE1
                    end
                    IDX_RESERVED_16: begin
                        st_d.reserved_16 = st_q.w_byte;
                    end
                    IDX_MON_CTRL_A: begin
                        st_d.monitor_control_a = st_q.w_byte; // RULE2 RULE3
                    end
                    IDX_MON_CTRL_B: begin
                        st_d.monitor_control_b = st_q.w_byte; // RULE4
                    end
                    IDX_PIN0_LIMITS: begin
                        st_d.pin0_voltage_limits = st_q.w_byte; // RULE5 RULE6
                    end
                    IDX_PIN1_LIMITS: begin
                        st_d.pin1_voltage_limits = st_q.w_byte; // RULE7 RULE8
                    end
                    IDX_TEMP_LIMITS: begin
                        st_d.temperature_limits = st_q.w_byte; // RULE9 RULE10
                    end
                    IDX_RX_ALARM_EN: begin
                        st_d.receiver_alarm_enables = st_q.w_byte; // RULE11 RULE12
                    end
                    IDX_MON_ALARM_EN: begin
                        st_d.monitor_alarm_enables = st_q.w_byte; // RULE13 RULE14
                    end
                    IDX_BC_ALARM_EN: begin
                        st_d.back_channel_alarm_enables = st_q.w_byte;
                    end
                    IDX_EVENT_MASK: begin
                        st_d.mon_msk = st_q.w_byte[5:0];
                    end
                    default: begin
                        st_d.bresp = st_d.bresp;
                    end
                endcase
            end
        end
        if (st_q.bvalid && i_s_axi_bready) begin
            st_d.bvalid = 1'b0;
        end
        // Receiver mask is above lane 0, so a write never changes it, whatever the strobes
        if (do_write && st_q.aw_idx == IDX_EVENT_MASK) begin
            st_d.rx_msk = st_q.rx_msk;
        end

        // Read clears status; an event in the same cycle still lands
        if (ar_take) begin
            st_d.rvalid = 1'b1;
            st_d.rdata = rd_data;
            st_d.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
            if (rd_idx == IDX_EVENT_STATUS) begin
                st_d.mon_sts = '0;
                st_d.rx_sts = '0;
            end
        end
        if (st_q.rvalid && i_s_axi_rready) begin
            st_d.rvalid = 1'b0;
        end
        // Flags record whatever the alarm enables say
        st_d.mon_sts = st_d.mon_sts | mon_set; // RULE15
        st_d.rx_sts = st_d.rx_sts | i_rx_err; // RULE15

        if (i_srst) begin
            st_d = '0;
            st_d.voltage_gain = RST_VOLTAGE_GAIN; // RULE1
            st_d.reserved_16 = RST_RESERVED_16;
            st_d.monitor_control_a = RST_MON_CTRL_A; // RULE2 RULE3
            st_d.monitor_control_b = RST_MON_CTRL_B; // RULE4
            st_d.pin0_voltage_limits = RST_LIMITS;
            st_d.pin1_voltage_limits = RST_LIMITS;
            st_d.temperature_limits = RST_LIMITS;
            st_d.receiver_alarm_enables = RST_RX_ALARM_EN; // RULE11 RULE12
            st_d.monitor_alarm_enables = RST_MON_ALARM_EN; // RULE13 RULE14
            st_d.back_channel_alarm_enables = RST_BC_ALARM_EN;
            st_d.mon_sts = RST_EVENTS;
            st_d.rx_sts = RST_EVENTS;
            st_d.mon_msk = RST_EVENTS;
            st_d.rx_msk = RST_EVENTS;
        end
    end

    always_ff @(posedge i_mclk) begin
        st_q <= st_d;
    end

    assign o_s_axi_bvalid = st_q.bvalid;
    assign o_s_axi_bresp = st_q.bresp;
    assign o_s_axi_rvalid = st_q.rvalid;
    assign o_s_axi_rresp = st_q.rresp;
    assign o_s_axi_rdata = st_q.rdata;

    // Gain of 128 over the code is applied by the analog front end
    assign o_cfg.voltage_gain_code = st_q.voltage_gain[GAIN_CODE_MSB:0]; // RULE1
    assign o_cfg.gain_apply = st_q.monitor_control_b[GAIN_APPLY_BIT]; // RULE4
    assign o_cfg.monitor_on = monitor_on; // RULE2
    assign o_cfg.pin_select = st_q.monitor_control_a[PIN_SEL_MSB:PIN_SEL_LSB]; // RULE3

    assign o_monitor_alarm = |(st_q.mon_sts & st_q.monitor_alarm_enables[5:0]); // RULE13 RULE14 RULE15
    assign o_rx_alarm = |(st_q.rx_sts & st_q.receiver_alarm_enables[5:0]); // RULE11 RULE12 RULE15
    assign o_irq = |({st_q.rx_sts, st_q.mon_sts} & {st_q.rx_msk, st_q.mon_msk});
endmodule

// ===== dv/mtac_asserts.sv
// Port-level assertions for the monitor threshold and alarm block
`timescale 1ns/100ps
module mtac_asserts (
    input wire logic i_mclk,
    input wire logic i_srst,
    input wire logic i_s_axi_awvalid,
    input wire logic o_s_axi_awready,
    input wire logic i_s_axi_wvalid,
    input wire logic o_s_axi_wready,
    input wire logic [1:0] o_s_axi_bresp,
    input wire logic o_s_axi_bvalid,
    input wire logic i_s_axi_bready,
    input wire logic i_s_axi_arvalid,
    input wire logic o_s_axi_arready,
    input wire logic [mtac_pkg::DATA_W-1:0] o_s_axi_rdata,
    input wire logic [1:0] o_s_axi_rresp,
    input wire logic o_s_axi_rvalid,
    input wire logic i_s_axi_rready,
    input wire mtac_pkg::mtac_meas_s i_meas,
    input wire logic [5:0] i_rx_err,
    input wire mtac_pkg::mtac_cfg_s o_cfg,
    input wire logic o_monitor_alarm,
    input wire logic o_rx_alarm,
    input wire logic o_irq
);
    import mtac_pkg::*;
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_srst);

    chk_ar_answer: assert property (o_s_axi_arready && i_s_axi_arvalid |=> o_s_axi_rvalid)
        else $error("read answer late");
    chk_r_stands: assert property (o_s_axi_rvalid && !i_s_axi_rready |=>
        o_s_axi_rvalid && $stable(o_s_axi_rdata) && $stable(o_s_axi_rresp)) else $error("read answer dropped");
    chk_ar_refused: assert property (o_s_axi_rvalid |-> !o_s_axi_arready) else $error("read taken while busy");
    // Both halves held one edge, response raised on the next
    chk_b_answer: assert property (o_s_axi_awready && i_s_axi_awvalid && o_s_axi_wready && i_s_axi_wvalid
        |-> ##2 o_s_axi_bvalid) else $error("write answer late");
    chk_b_stands: assert property (o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid && $stable(o_s_axi_bresp))
        else $error("write answer dropped");
    chk_w_refused: assert property (o_s_axi_bvalid |-> !o_s_axi_awready && !o_s_axi_wready)
        else $error("write taken while busy");
    chk_cfg_reset: assert property ($past(i_srst) |-> o_cfg == 11'h441)
        else $error("config not at reset value");
    // Alarms may only rise from an event or from an enable write
    chk_rx_cause: assert property ($rose(o_rx_alarm) |-> ($past(i_rx_err) != 6'h00) || $rose(o_s_axi_bvalid))
        else $error("receiver alarm without cause");
    chk_mon_cause: assert property ($rose(o_monitor_alarm) |->
        ($past(i_meas.valid) && $past(o_cfg.monitor_on)) || $rose(o_s_axi_bvalid))
        else $error("monitor alarm without cause");

    cover property (o_s_axi_bvalid && i_s_axi_bready);
    cover property (o_s_axi_rvalid && o_s_axi_rresp == RESP_SLVERR);
    cover property ($rose(o_monitor_alarm));
    cover property (o_irq);
endmodule

bind mtac_core mtac_asserts mtac_asserts_inst (.i_mclk, .i_srst, .i_s_axi_awvalid, .o_s_axi_awready,
    .i_s_axi_wvalid, .o_s_axi_wready, .o_s_axi_bresp, .o_s_axi_bvalid, .i_s_axi_bready, .i_s_axi_arvalid,
    .o_s_axi_arready, .o_s_axi_rdata, .o_s_axi_rresp, .o_s_axi_rvalid, .i_s_axi_rready, .i_meas, .i_rx_err,
    .o_cfg, .o_monitor_alarm, .o_rx_alarm, .o_irq);

// ===== dv/test_mtac_core.sv
// Self-checking bench for the monitor threshold and alarm block
`timescale 1ns/100ps
module test_mtac_core;
    import mtac_pkg::*;
    logic i_mclk, i_srst, i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready, i_s_axi_arvalid, i_s_axi_rready;
    logic [ADDR_W-1:0] i_s_axi_awaddr, i_s_axi_araddr;
    logic [DATA_W-1:0] i_s_axi_wdata, o_s_axi_rdata;
    logic [3:0] i_s_axi_wstrb;
    logic [1:0] o_s_axi_bresp, o_s_axi_rresp;
    logic o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid;
    logic [5:0] i_rx_err;
    mtac_meas_s i_meas;
    mtac_cfg_s o_cfg;
    logic o_monitor_alarm, o_rx_alarm, o_irq;
    int error_cnt = 0;
    int checks_done = 0;

    mtac_core mtac_core_inst (.i_mclk, .i_srst, .i_s_axi_awaddr, .i_s_axi_awvalid, .o_s_axi_awready,
        .i_s_axi_wdata, .i_s_axi_wstrb, .i_s_axi_wvalid, .o_s_axi_wready, .o_s_axi_bresp, .o_s_axi_bvalid,
        .i_s_axi_bready, .i_s_axi_araddr, .i_s_axi_arvalid, .o_s_axi_arready, .o_s_axi_rdata, .o_s_axi_rresp,
        .o_s_axi_rvalid, .i_s_axi_rready, .i_meas, .i_rx_err, .o_cfg, .o_monitor_alarm, .o_rx_alarm, .o_irq);

    initial begin
        i_mclk = 1'b0;
        forever #50 i_mclk = ~i_mclk;
    end

    task automatic final_report();
        $display("Checks %0d, errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: value %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp_bit(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: flag %b, expected %b", $time, got, exp);
        end
    endtask

    // Both halves offered together, each dropped once taken; no fixed latency assumed
    // Response ready stays high between transfers, so a back-to-back call never lowers and raises it at one edge
    task automatic axi_write(input logic [5:0] idx, input logic [7:0] dat, input logic [1:0] rsp);
        int n;
        logic aw_done;
        logic w_done;
        n = 0;
        aw_done = 1'b0;
        w_done = 1'b0;
        i_s_axi_awaddr <= {idx, 2'b00};
        i_s_axi_wdata <= {24'h00_0000, dat};
        i_s_axi_awvalid <= 1'b1;
        i_s_axi_wvalid <= 1'b1;
        i_s_axi_bready <= 1'b1;
        do begin
            @(posedge i_mclk);
            n++;
            if (!aw_done && o_s_axi_awready) begin
                aw_done = 1'b1;
                i_s_axi_awvalid <= 1'b0;
            end
            if (!w_done && o_s_axi_wready) begin
                w_done = 1'b1;
                i_s_axi_wvalid <= 1'b0;
            end
        end while (!o_s_axi_bvalid && n < 50);
        cmp_bit(o_s_axi_bvalid, 1'b1);
        cmp_val(32'(o_s_axi_bresp), 32'(rsp));
    endtask

    task automatic axi_read(input logic [5:0] idx, input logic [31:0] exp, input logic [1:0] rsp);
        int n;
        n = 0;
        i_s_axi_araddr <= {idx, 2'b00};
        i_s_axi_arvalid <= 1'b1;
        i_s_axi_rready <= 1'b1;
        do begin
            @(posedge i_mclk);
            n++;
            if (o_s_axi_arready) begin
                i_s_axi_arvalid <= 1'b0;
            end
        end while (!o_s_axi_rvalid && n < 50);
        cmp_bit(o_s_axi_rvalid, 1'b1);
        cmp_val(o_s_axi_rdata, exp);
        cmp_val(32'(o_s_axi_rresp), 32'(rsp));
    endtask

    // One-cycle sample; flags land one edge later
    task automatic mon_sample(input logic [7:0] ctl, input logic [2:0] p0, input logic [2:0] p1, input logic [2:0] t);
        axi_write(IDX_MON_CTRL_A, ctl, RESP_OKAY);
        i_meas <= {1'b1, p0, p1, t};
        @(posedge i_mclk);
        i_meas.valid <= 1'b0;
        @(posedge i_mclk);
    endtask

    task automatic rx_event(input logic [5:0] ev, input logic alarm_exp, input logic [31:0] sts);
        i_rx_err <= ev;
        @(posedge i_mclk);
        i_rx_err <= 6'h00;
        @(posedge i_mclk);
        cmp_bit(o_rx_alarm, alarm_exp);
        axi_read(IDX_EVENT_STATUS, sts, RESP_OKAY);
        cmp_bit(o_rx_alarm, 1'b0);
    endtask

    task automatic t_reset();
        logic [7:0] rst [10] = '{8'h20, 8'h18, 8'h0c, 8'h80, 8'h62, 8'h62, 8'h62, 8'h3f, 8'h00, 8'h00};
        cmp_val(32'(o_cfg), 32'h0000_0441);
        cmp_bit(o_irq | o_monitor_alarm | o_rx_alarm, 1'b0);
        for (int i = 0; i < 10; i++) begin
            axi_read(6'h15 + 6'(i), 32'(rst[i]), RESP_OKAY);
        end
        axi_read(IDX_EVENT_STATUS, 32'h0000_0000, RESP_OKAY);
    endtask

    task automatic t_regs();
        axi_write(IDX_VOLTAGE_GAIN, 8'h40, RESP_OKAY);
        axi_write(IDX_MON_CTRL_B, 8'h00, RESP_OKAY);
        // Enable code 10 is not a documented on value
        axi_write(IDX_MON_CTRL_A, 8'h0b, RESP_OKAY);
        cmp_val(32'(o_cfg), 32'h0000_0380);
        axi_read(IDX_VOLTAGE_GAIN, 32'h0000_0040, RESP_OKAY);
        // Lane 0 strobe off: answered OKAY, register untouched
        i_s_axi_wstrb <= 4'he;
        axi_write(IDX_VOLTAGE_GAIN, 8'h10, RESP_OKAY);
        i_s_axi_wstrb <= 4'hf;
        axi_read(IDX_VOLTAGE_GAIN, 32'h0000_0040, RESP_OKAY);
        axi_write(IDX_BC_ALARM_EN, 8'ha5, RESP_OKAY);
        axi_read(IDX_BC_ALARM_EN, 32'h0000_00a5, RESP_OKAY);
        axi_write(6'h3f, 8'h11, RESP_SLVERR);
        axi_read(6'h3f, 32'h0000_0000, RESP_SLVERR);
    endtask

    task automatic t_mon();
        logic [7:0] ctl [5] = '{8'h0f, 8'h0e, 8'h0d, 8'h0c, 8'h03};
        logic [11:0] lvl [5] = '{12'h717, 12'h776, 12'h101, 12'h072, 12'h777};
        logic [7:0] sts [5] = '{8'h26, 8'h08, 8'h11, 8'h00, 8'h00};
        for (int i = 0; i < 5; i++) begin
            mon_sample(ctl[i], lvl[i][10:8], lvl[i][6:4], lvl[i][2:0]);
            axi_read(IDX_EVENT_STATUS, 32'(sts[i]), RESP_OKAY);
        end
        axi_write(IDX_PIN0_LIMITS, 8'h30, RESP_OKAY);
        axi_write(IDX_PIN1_LIMITS, 8'h35, RESP_OKAY);
        axi_write(IDX_TEMP_LIMITS, 8'h45, RESP_OKAY);
        mon_sample(8'h0f, 3'h4, 3'h4, 3'h5);
        axi_read(IDX_EVENT_STATUS, 32'h0000_002e, RESP_OKAY);
    endtask

    task automatic t_alarm();
        mon_sample(8'h0c, 3'h0, 3'h4, 3'h7);
        cmp_bit(o_monitor_alarm, 1'b0);
        axi_write(IDX_MON_ALARM_EN, 8'h20, RESP_OKAY);
        cmp_bit(o_monitor_alarm, 1'b1);
        cmp_bit(o_irq, 1'b0);
        axi_write(IDX_EVENT_MASK, 8'h20, RESP_OKAY);
        cmp_bit(o_irq, 1'b1);
        axi_read(IDX_EVENT_STATUS, 32'h0000_0020, RESP_OKAY);
        cmp_bit(o_monitor_alarm | o_irq, 1'b0);
        axi_write(IDX_MON_ALARM_EN, 8'h02, RESP_OKAY);
        mon_sample(8'h0f, 3'h7, 3'h4, 3'h4);
        cmp_bit(o_monitor_alarm, 1'b1);
        cmp_bit(o_irq, 1'b0);
        axi_read(IDX_EVENT_STATUS, 32'h0000_001e, RESP_OKAY);
    endtask

    task automatic t_rx();
        for (int b = 0; b < 6; b++) begin
            rx_event(6'(1 << b), 1'b1, 32'(1 << (b + 8)));
        end
        axi_write(IDX_RX_ALARM_EN, 8'h3e, RESP_OKAY);
        rx_event(6'h01, 1'b0, 32'h0000_0100);
    endtask

    initial begin
        i_srst = 1'b1;
        {i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready, i_s_axi_arvalid, i_s_axi_rready} = 5'h00;
        i_s_axi_awaddr = 8'h00;
        i_s_axi_araddr = 8'h00;
        i_s_axi_wdata = 32'h0000_0000;
        i_s_axi_wstrb = 4'hf;
        i_rx_err = 6'h00;
        i_meas = '0;
        repeat (5) @(posedge i_mclk);
        i_srst <= 1'b0;
        t_reset();
        t_regs();
        t_mon();
        t_alarm();
        t_rx();
        final_report();
    end

    // Whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge i_mclk);
        error_cnt++;
        final_report();
    end
endmodule
